// [hw/lpm_power_control.sv]
// power control register with idle and power-down sequencing behind an APB slave
// Notes on behaviour
// [R1] writing one to bit 1 of the power control register enters power-down
// [R2] power-down halts the cpu and stops the oscillator clock
// [R3] cpu reset or an interrupt ends power-down and resumes operation
// [R4] bit 2 is a plain software flag for telling idle wake-ups apart
// [R5] bit 3 is a plain software flag for telling power-down wake-ups apart
// [R6] bit 4 always reads as one whatever was written
// [R7] writing one to bit 0 enters idle; cpu halts, clock and peripherals run
`timescale 1ns/1ns
`default_nettype none
module lpm_power_control
	import lpm_pkg::*;
(
	input  wire logic        core_clk,     // 250 MHz system clock
	input  wire logic        sys_rst,      // cpu reset, synchronous, active high
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb access phase
	input  wire logic        pwrite,       // apb direction, high for write
	input  wire logic [11:0] paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic      [31:0] prdata,       // apb read data
	output logic             pready,       // apb transfer done
	output logic             pslverr,      // apb error on unmapped address
	input  wire logic        wakeRequest,  // interrupt request level from pins
	output lpm_pkg::lpm_status_s powerStatus // gating controls for the chip
);
	import lpm_pkg::*;

	lpm_mode_e   mode_r;
	lpm_mode_e   mode_nxt;
	logic        userFlagZero_r;
	logic        userFlagOne_r;
	logic        wakeSync;
	logic        accessDone;
	logic        writeHit;
	logic [7:0]  ctrlView;

	function automatic logic addrHit(input logic [11:0] addr);
		return addr == LPM_CTRL_ADDR;
	endfunction : addrHit

	lpm_sync #(.WIDTH(1)) wakeSyncInst (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.asyncIn  (wakeRequest),
		.syncOut  (wakeSync)
	);

	// one wait state keeps every bus output registered
	assign accessDone = psel & penable & pready;
	assign writeHit   = accessDone & pwrite & addrHit(paddr);

	always_comb begin
		ctrlView                = 8'h00;
		ctrlView[LPM_IDLE_BIT]  = (mode_r == LPM_IDLE);
		ctrlView[LPM_PDOWN_BIT] = (mode_r == LPM_PDOWN);
		ctrlView[LPM_FLAG0_BIT] = userFlagZero_r;
		ctrlView[LPM_FLAG1_BIT] = userFlagOne_r;
		ctrlView[LPM_RSVD_BIT]  = LPM_RSVD_VALUE; // R6
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addrHit(paddr);
			if (psel & penable & ~pready & ~pwrite & addrHit(paddr)) begin
				prdata <= {24'h00_0000, ctrlView};
			end else if (psel & penable & ~pready) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// power-down takes precedence when both request bits are written together,
	// since it is the deeper state; a wake seen in the same cycle still wins
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			LPM_RUN: begin
				if (writeHit && !wakeSync && pwdata[LPM_PDOWN_BIT]) begin
					mode_nxt = LPM_PDOWN; // R1
				end else if (writeHit && !wakeSync && pwdata[LPM_IDLE_BIT]) begin
					mode_nxt = LPM_IDLE; // R7
				end
			end
			LPM_IDLE: begin
				if (wakeSync) begin
					mode_nxt = LPM_RUN; // R7
				end
			end
			LPM_PDOWN: begin
				if (wakeSync) begin
					mode_nxt = LPM_RUN; // R3
				end
			end
			default: begin
				mode_nxt = LPM_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_r <= LPM_RUN; // R3
		end else begin
			mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			userFlagZero_r <= LPM_CTRL_RESET[LPM_FLAG0_BIT];
			userFlagOne_r  <= LPM_CTRL_RESET[LPM_FLAG1_BIT];
		end else if (writeHit) begin
			userFlagZero_r <= pwdata[LPM_FLAG0_BIT]; // R4
			userFlagOne_r  <= pwdata[LPM_FLAG1_BIT]; // R5
		end
	end

	// the core clock itself is the always-on timebase; the oscillator that
	// power-down stops is represented by the oscRun enable
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			powerStatus <= '{cpuHalt: 1'b0, oscRun: 1'b1, periphRun: 1'b1};
		end else begin
			powerStatus.cpuHalt   <= (mode_nxt != LPM_RUN); // R2 R7
			powerStatus.oscRun    <= (mode_nxt != LPM_PDOWN); // R2
			powerStatus.periphRun <= (mode_nxt != LPM_PDOWN); // R7
		end
	end

	enter_pdown_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		(mode_r == LPM_RUN && writeHit && pwdata[LPM_PDOWN_BIT] && !wakeSync)
		|=> (mode_r == LPM_PDOWN) ##0 !powerStatus.oscRun)
		else $error("power-down write did not enter power-down");

	pdown_gating_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		(mode_r == LPM_PDOWN) |-> (powerStatus.cpuHalt && !powerStatus.oscRun))
		else $error("power-down left cpu or oscillator running");

	pdown_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
		(mode_r == LPM_PDOWN && wakeSync) |=> (mode_r == LPM_RUN && !powerStatus.cpuHalt
		&& powerStatus.oscRun))
		else $error("interrupt did not end power-down");

	flag_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		writeHit |=> (userFlagZero_r == $past(pwdata[LPM_FLAG0_BIT])))
		else $error("user flag zero not stored");

	flag_one_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		!writeHit |=> $stable(userFlagOne_r))
		else $error("user flag one changed without a write");

	rsvd_reads_one_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
		(psel && penable && !pready && !pwrite && addrHit(paddr))
		|=> pready && prdata[LPM_RSVD_BIT] && prdata[31:8] == 24'h00_0000)
		else $error("reserved bit did not read as one");

	idle_gating_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		(mode_r == LPM_RUN && writeHit && pwdata[LPM_IDLE_BIT] && !pwdata[LPM_PDOWN_BIT]
		&& !wakeSync) |=> (mode_r == LPM_IDLE) ##0 (powerStatus.cpuHalt
		&& powerStatus.oscRun && powerStatus.periphRun))
		else $error("idle did not halt cpu with clocks running");

	idle_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		(mode_r == LPM_IDLE && wakeSync) |=> ##[0:1] !powerStatus.cpuHalt)
		else $error("interrupt did not end idle");

	flag_one_store_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		writeHit
		|=> (userFlagOne_r == $past(pwdata[LPM_FLAG1_BIT])))
		else $error("user flag one not stored");

	flag_zero_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		!writeHit
		|=> $stable(userFlagZero_r))
		else $error("user flag zero changed without a write");

	flag_no_effect_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4 R5
		(mode_r == LPM_RUN && writeHit && !pwdata[LPM_IDLE_BIT] && !pwdata[LPM_PDOWN_BIT])
		|=> (mode_r == LPM_RUN && !powerStatus.cpuHalt))
		else $error("flag write changed the power mode");

	pdown_periph_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		(mode_r == LPM_PDOWN)
		|-> !powerStatus.periphRun)
		else $error("power-down left peripherals clocked");

	pdown_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		(mode_r == LPM_PDOWN && !wakeSync)
		|=> (mode_r == LPM_PDOWN))
		else $error("power-down ended without a wake");

	idle_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		(mode_r == LPM_IDLE && !wakeSync)
		|=> (mode_r == LPM_IDLE))
		else $error("idle ended without a wake");

	idle_clocks_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		(mode_r == LPM_IDLE)
		|-> (powerStatus.cpuHalt && powerStatus.oscRun && powerStatus.periphRun))
		else $error("idle gating wrong while idle");

	run_clocks_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
		(mode_r == LPM_RUN)
		|-> (!powerStatus.cpuHalt && powerStatus.oscRun && powerStatus.periphRun))
		else $error("run mode left something gated");

	reset_wake_a: assert property (@(posedge core_clk) // R3
		sys_rst
		|=> (mode_r == LPM_RUN && !powerStatus.cpuHalt && powerStatus.oscRun))
		else $error("cpu reset did not end the low power mode");

	pdown_reads_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		(psel && penable && !pready && !pwrite && addrHit(paddr) && mode_r == LPM_PDOWN)
		|=> (prdata[LPM_PDOWN_BIT] && !prdata[LPM_IDLE_BIT]))
		else $error("power-down bit did not read back as one");
endmodule : lpm_power_control
`default_nettype wire

// [hw/lpm_pkg.sv]
// constants and carrier types for the low power mode control block
package lpm_pkg;
	localparam int unsigned   LPM_CTRL_INDEX    = 32'h0000_0087;
	localparam logic [11:0]   LPM_CTRL_ADDR     = 12'(LPM_CTRL_INDEX * 4);
	localparam int unsigned   LPM_IDLE_BIT      = 0;
	localparam int unsigned   LPM_PDOWN_BIT     = 1;
	localparam int unsigned   LPM_FLAG0_BIT     = 2;
	localparam int unsigned   LPM_FLAG1_BIT     = 3;
	localparam int unsigned   LPM_RSVD_BIT      = 4;
	localparam logic          LPM_RSVD_VALUE    = 1'b1;
	localparam logic [7:0]    LPM_CTRL_RESET    = 8'h10;
	localparam int unsigned   LPM_SYNC_STAGES   = 2;

	typedef enum logic [1:0] {
		LPM_RUN   = 2'b00,
		LPM_IDLE  = 2'b01,
		LPM_PDOWN = 2'b10
	} lpm_mode_e;

	typedef struct packed {
		logic cpuHalt;     // cpu stops fetching
		logic oscRun;      // oscillator clock enabled
		logic periphRun;   // timers, interrupt logic, serial port clocked
	} lpm_status_s;
endpackage : lpm_pkg

// [hw/lpm_sync.sv]
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module lpm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             core_clk,  // system clock
	input  wire logic             sys_rst,   // synchronous reset, active high
	input  wire logic [WIDTH-1:0] asyncIn,   // raw level from a pin
	output logic      [WIDTH-1:0] syncOut    // level safe for core logic
);
	logic [WIDTH-1:0] stageOne_r;

	// first stage is read by the second stage only
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stageOne_r <= '0;
			syncOut    <= '0;
		end else begin
			stageOne_r <= asyncIn;
			syncOut    <= stageOne_r;
		end
	end
endmodule : lpm_sync
`default_nettype wire

// [bench/test_lpm_power_control.sv]
// self-checking apb testbench for the low power mode control block
`timescale 1ns/1ns
`default_nettype none
module test_lpm_power_control;
	import lpm_pkg::*;
	logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic        wakeRequest = 0, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	lpm_status_s powerStatus;
	// note layout: read flag, pslverr, powerStatus, prdata
	logic [36:0] q[$];
	logic [36:0] n;
	logic [35:0] e, g;
	logic [3:0]  f;
	int          miscompares = 0, num_checks = 0, cyc = 0;
	always #2 core_clk = ~core_clk;
	lpm_power_control uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wakeRequest(wakeRequest), .powerStatus(powerStatus));
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	function automatic logic [36:0] rd(input logic [7:0] v, input logic [2:0] s);
		return {2'b10, s, 24'h0, v};
	endfunction : rd
	// one idle cycle after each transfer keeps psel from being assigned twice in a step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [36:0] x);
		q.push_back(x);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask : xfer
	task automatic chk(input logic [7:0] v, input logic [2:0] s);
		xfer(0, LPM_CTRL_ADDR, $urandom, rd(v, s));
	endtask : chk
	task automatic wr(input logic [7:0] v);
		xfer(1, LPM_CTRL_ADDR, ($urandom & 32'hFFFF_FF00) | 32'(v), {2'b00, 35'h0});
	endtask : wr
	// wake level is held long enough to cross the synchroniser, then flushed
	task automatic wake;
		wakeRequest <= 1;
		repeat (6) @(posedge core_clk);
		wakeRequest <= 0;
		repeat (6) @(posedge core_clk);
	endtask : wake
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			results();
		end
	end
	always @(posedge core_clk) begin
		if (pready === 1'b1) begin
			n = (q.size() > 0) ? q.pop_front() : '1;
			e = n[35:0];
			g = {pslverr, powerStatus, prdata};
			if (n[36] !== 1'b1) begin
				e[34:0] = '0;
				g[34:0] = '0;
			end
			num_checks++;
			if (g !== e) begin
				miscompares++;
				$display("BAD apb expected %h seen %h", e, g);
			end
		end
	end
	initial begin
		void'($urandom(89));
		repeat (4) @(posedge core_clk);
		sys_rst <= 0;
		@(posedge core_clk);
		chk(8'h10, 3'b011);
		$display("reset test done");
		for (int m = 0; m < 2; m++) begin
			f = 4'($urandom) & 4'hC;
			wr({4'h0, f} | 8'(1 << m));
			chk({4'h1, f} | 8'(1 << m), m ? 3'b100 : 3'b111);
			wake();
			chk({4'h1, f}, 3'b011);
			$display("mode %0d test done", m);
		end
		wr(8'h02);
		sys_rst <= 1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 0;
		@(posedge core_clk);
		chk(8'h10, 3'b011);
		$display("reset wake test done");
		xfer(1, LPM_CTRL_ADDR + 12'h4, 32'h2, {2'b01, 35'h0});
		xfer(0, LPM_CTRL_ADDR + 12'h4, 32'h0, {2'b11, 3'b011, 32'h0});
		chk(8'h10, 3'b011);
		$display("unmapped test done");
		wr(8'hEC);
		chk(8'h1C, 3'b011);
		$display("flag test done");
		results();
	end
endmodule : test_lpm_power_control
`default_nettype wire
